// ===== sim/ext_serial_dev.sv
`timescale 1ns/1ps
// ==========================================
// External serial device, clock master
module ext_serial_dev #(
	parameter int half_period = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      bit_clock,
	output logic      frame_sync,
	output logic      data
);
	logic [7:0] cnt;
	// Never frames, so an enabled transmitter sees no sync
	assign frame_sync = 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h0;
			bit_clock <= 1'b0;
			data <= 1'b0;
		end else begin
			// Idle line keeps changing, no stale bit
			data <= ~data;
			if (!run) begin
				cnt <= 8'h0;
				bit_clock <= 1'b0;
			end else if (cnt == 8'(half_period - 1)) begin
				cnt <= 8'h0;
				bit_clock <= ~bit_clock;
			end else begin
				cnt <= cnt + 8'h1;
			end
		end
	end
endmodule : ext_serial_dev

// ===== sim/serial_port_reset_init_properties.sv
`timescale 1ns/1ps
// ==========================================
// Reset and start-up properties
module serial_port_reset_init_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        rx_bit_clock_out,
	input wire logic        tx_bit_clock_out,
	input wire logic        rx_frame_sync_out,
	input wire logic        tx_frame_sync_out,
	input wire logic        serial_data_out_oe,
	input wire logic        tx_dma_event,
	input wire logic        rx_dma_event,
	input wire logic        tx_interrupt,
	input wire logic        rx_interrupt,
	input wire logic        rx_uses_rate_gen,
	input wire logic        rx_uses_frame_gen,
	input wire logic        tx_uses_rate_gen,
	input wire logic        tx_uses_frame_gen
);
	logic [31:0] pctl, pin, cfg;
	logic        wr, rx_on, tx_on, gen_on, clk_q, seg_ok;
	logic [8:0]  run;
	assign wr = psel && penable && pwrite && pready;
	assign rx_on = pctl[sp_reset_pkg::receiver_reset_bit];
	assign tx_on = pctl[sp_reset_pkg::transmitter_reset_bit];
	assign gen_on = pctl[sp_reset_pkg::rate_gen_reset_bit];
	// ==========================================
	// Shadow of what software last wrote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pctl <= sp_reset_pkg::port_control_reset;
			pin <= sp_reset_pkg::pin_control_reset;
			cfg <= sp_reset_pkg::rate_gen_config_reset;
		end else if (wr && paddr == sp_reset_pkg::emu_reset_off
				&& pwdata == sp_reset_pkg::emu_reset_key) begin
			pctl <= sp_reset_pkg::port_control_reset;
			pin <= sp_reset_pkg::pin_control_reset;
			cfg <= sp_reset_pkg::rate_gen_config_reset;
		end else if (wr && paddr == sp_reset_pkg::port_control_off) begin
			pctl <= pwdata;
		end else if (wr && paddr == sp_reset_pkg::pin_control_off) begin
			pin <= pwdata;
		end else if (wr && paddr == sp_reset_pkg::rate_gen_config_off) begin
			cfg <= pwdata;
		end
	end
	// ==========================================
	// Length of each generated clock level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			run <= 9'h0;
			seg_ok <= 1'b0;
		end else begin
			clk_q <= rx_bit_clock_out;
			if (!gen_on) begin
				run <= 9'h0;
				seg_ok <= 1'b0;
			end else if (rx_bit_clock_out != clk_q) begin
				run <= 9'h1;
				seg_ok <= 1'b1;
			end else begin
				run <= run + 9'h1;
			end
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence gen_started;
		$rose(gen_on);
	endsequence
	gen_clock_low_a: assert property (!gen_on && !$past(gen_on) |->
		!rx_bit_clock_out && !tx_bit_clock_out) else $error("clock not low");
	gen_clock_start_a: assert property (gen_started |-> ##[1:2]
		rx_bit_clock_out) else $error("clock did not start");
	clock_period_a: assert property (gen_on && seg_ok &&
		rx_bit_clock_out != clk_q |-> run == {1'b0, cfg[7:0]} + 9'h1)
		else $error("clock period wrong");
	tx_sync_idle_a: assert property (!tx_on |-> tx_frame_sync_out ==
		pin[sp_reset_pkg::tx_fs_pol_bit]) else $error("tx sync active");
	rx_sync_idle_a: assert property (!rx_on |-> rx_frame_sync_out ==
		pin[sp_reset_pkg::rx_fs_pol_bit]) else $error("rx sync active");
	data_hiz_a: assert property (serial_data_out_oe == tx_on)
		else $error("data enable wrong");
	rx_quiet_a: assert property (!rx_on |-> !rx_dma_event &&
		!rx_interrupt) else $error("rx request in reset");
	tx_quiet_a: assert property (!tx_on |-> !tx_dma_event &&
		!tx_interrupt) else $error("tx request in reset");
	rx_gen_use_a: assert property (rx_uses_frame_gen == pin[2] &&
		rx_uses_rate_gen == (pin[0] || pin[2])) else $error("rx use wrong");
	tx_gen_use_a: assert property (tx_uses_rate_gen == pin[1] &&
		tx_uses_frame_gen == (pin[1] && pin[3] && pin[6]))
		else $error("tx use wrong");
endmodule : serial_port_reset_init_checker

bind serial_port_reset_init serial_port_reset_init_checker i_checker (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.rx_bit_clock_out, .tx_bit_clock_out, .rx_frame_sync_out,
	.tx_frame_sync_out, .serial_data_out_oe, .tx_dma_event, .rx_dma_event,
	.tx_interrupt, .rx_interrupt, .rx_uses_rate_gen, .rx_uses_frame_gen,
	.tx_uses_rate_gen, .tx_uses_frame_gen);

// ===== sim/test_serial_port_reset_init.sv
`timescale 1ns/1ps
module test_serial_port_reset_init;
	logic        pclk, presetn, psel, penable, pwrite, ext_run;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, rx_bit_clock_out, tx_bit_clock_out;
	logic        rx_frame_sync_out, tx_frame_sync_out, serial_data_out_oe;
	logic        tx_dma_event, rx_dma_event, tx_interrupt, rx_interrupt;
	logic        rx_uses_rate_gen, rx_uses_frame_gen;
	logic        tx_uses_rate_gen, tx_uses_frame_gen;
	logic        ext_clk, ext_fs, ext_data;
	int          err_count, checks_done;

	serial_port_reset_init i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
		.rx_bit_clock_in(ext_clk), .rx_bit_clock_out, .rx_bit_clock_oe(),
		.rx_frame_sync_in(ext_fs), .rx_frame_sync_out, .rx_frame_sync_oe(),
		.tx_bit_clock_in(ext_clk), .tx_bit_clock_out, .tx_bit_clock_oe(),
		.tx_frame_sync_in(ext_fs), .tx_frame_sync_out, .tx_frame_sync_oe(),
		.serial_data_out(), .serial_data_out_oe, .serial_data_in(ext_data),
		.tx_dma_event, .rx_dma_event, .tx_interrupt, .rx_interrupt,
		.rx_uses_rate_gen, .rx_uses_frame_gen, .tx_uses_rate_gen,
		.tx_uses_frame_gen);
	ext_serial_dev i_ext (.pclk, .presetn, .run(ext_run),
		.bit_clock(ext_clk), .frame_sync(ext_fs), .data(ext_data));

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	task automatic fail(input string msg);
		$display("mismatch at %0t: %s", $time, msg);
		err_count++;
	endtask : fail
	task automatic check32(input logic [31:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) fail(what);
	endtask : check32
	task automatic check1(input logic got, exp, input string what);
		checks_done++;
		if (got !== exp) fail(what);
	endtask : check1
	// ==========================================
	// Bus master
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			fail("no ready");
			wrap_up;
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask : wr32
	// Status bits may move on their own, so they are masked off
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e,
			input string what);
		logic [31:0] q;
		apb(a, 1'b0, 32'h0, q);
		check32(q & m, e, what);
	endtask : rd_chk
	task automatic regs_default(input string what);
		rd_chk(sp_reset_pkg::port_control_off, 32'hf, 32'h0, what);
		rd_chk(sp_reset_pkg::rate_gen_config_off, 32'hffff_ffff,
			sp_reset_pkg::rate_gen_config_reset, what);
		rd_chk(sp_reset_pkg::pin_control_off, 32'hffff_ffff, 32'h0, what);
		check1(serial_data_out_oe, 1'b0, what);
	endtask : regs_default
	// ==========================================
	// Scenarios
	task automatic test_reset_state;
		regs_default("after reset");
		rd_chk(8'h14, 32'hffff_ffff, 32'h0, "unmapped");
		$display("test_reset_state done");
	endtask : test_reset_state
	task automatic test_sync_error;
		logic [31:0] q;
		int n;
		ext_run <= 1'b1;
		wr32(sp_reset_pkg::port_control_off, 32'h2);
		n = 0;
		do begin
			apb(sp_reset_pkg::port_control_off, 1'b0, 32'h0, q);
			n++;
		end while (q[7] !== 1'b1 && n < 20);
		check1(q[7], 1'b1, "sync error seen");
		wr32(sp_reset_pkg::port_control_off, 32'h0);
		apb(sp_reset_pkg::port_control_off, 1'b0, 32'h0, q);
		check1(q[7], 1'b0, "sync error cleared");
		ext_run <= 1'b0;
		$display("test_sync_error done");
	endtask : test_sync_error
	task automatic test_idle_levels;
		int n;
		wr32(sp_reset_pkg::pin_control_off, 32'h3f);
		@(negedge pclk);
		check1(tx_frame_sync_out, 1'b1, "tx sync idle");
		check1(rx_frame_sync_out, 1'b1, "rx sync idle");
		wr32(sp_reset_pkg::port_control_off, 32'h4);
		n = 0;
		while (tx_bit_clock_out !== 1'b1 && n < 8) begin
			@(negedge pclk);
			n++;
		end
		check1(tx_bit_clock_out, 1'b1, "clock in reset");
		check1(tx_frame_sync_out, 1'b1, "sync masked");
		wr32(sp_reset_pkg::port_control_off, 32'h6);
		@(negedge pclk);
		check1(serial_data_out_oe, 1'b1, "data driven");
		check1(rx_frame_sync_out, 1'b1, "rx untouched");
		// Frame generator runs; only the live receiver shows it
		wr32(sp_reset_pkg::port_control_off, 32'hd);
		n = 0;
		while (rx_frame_sync_out !== 1'b0 && n < 64) begin
			@(negedge pclk);
			n++;
		end
		check1(rx_frame_sync_out, 1'b0, "rx sync from generator");
		check1(tx_frame_sync_out, 1'b1, "tx sync held idle");
		check1(rx_dma_event, 1'b1, "rx event");
		check1(rx_interrupt, 1'b1, "rx interrupt");
		check1(serial_data_out_oe, 1'b0, "data released");
		wr32(sp_reset_pkg::port_control_off, 32'h0);
		repeat (2) @(negedge pclk);
		check1(rx_bit_clock_out, 1'b0, "clock stopped");
		$display("test_idle_levels done");
	endtask : test_idle_levels
	task automatic test_gen_uses;
		for (int i = 0; i < 8; i++) begin
			if (i == 6) continue;
			wr32(sp_reset_pkg::pin_control_off,
				{25'h0, i[2], 2'b00, i[1], i[1], i[0], i[0]});
			@(negedge pclk);
			check1(rx_uses_rate_gen, i[0] | i[1], "rx rate use");
			check1(rx_uses_frame_gen, i[1], "rx frame use");
			check1(tx_uses_frame_gen, i[0] & i[1] & i[2], "tx frame");
		end
		$display("test_gen_uses done");
	endtask : test_gen_uses
	task automatic test_frame_start;
		logic [31:0] q;
		int n;
		wr32(sp_reset_pkg::rate_gen_config_off, 32'h0301);
		wr32(sp_reset_pkg::pin_control_off, 32'h4a);
		repeat (2) @(posedge pclk);
		wr32(sp_reset_pkg::port_control_off, 32'h4);
		repeat (8) @(posedge pclk);
		wr32(sp_reset_pkg::port_control_off, 32'h6);
		repeat (2) @(negedge pclk);
		check1(tx_dma_event, 1'b1, "tx event");
		wr32(sp_reset_pkg::transmit_holding_off, 32'h5a5a_5a5a);
		n = 0;
		do begin
			apb(sp_reset_pkg::port_control_off, 1'b0, 32'h0, q);
			n++;
		end while (q[6] !== 1'b1 && n < 8);
		check1(q[6], 1'b1, "shift loaded");
		wr32(sp_reset_pkg::port_control_off, 32'he);
		n = 0;
		while (tx_frame_sync_out !== 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		// Generated period is four cycles at divider one
		check1(n >= 28 && n <= 36, 1'b1, "first frame delay");
		$display("test_frame_start done");
	endtask : test_frame_start
	task automatic test_emu;
		wr32(sp_reset_pkg::pin_control_off, 32'h3f);
		wr32(sp_reset_pkg::emu_reset_off, sp_reset_pkg::emu_reset_key);
		regs_default("after emulator reset");
		$display("test_emu done");
	endtask : test_emu
	// ==========================================
	// Main sequence
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, ext_run} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		err_count = 0;
		checks_done = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		test_reset_state;
		test_sync_error;
		test_idle_levels;
		test_gen_uses;
		test_frame_start;
		test_emu;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail("run too long");
		wrap_up;
	end
endmodule : test_serial_port_reset_init

// ===== verilog/serial_port_reset_init.sv
`timescale 1ns/1ps
// ==========================================
// Serial port reset and start-up control
module serial_port_reset_init (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_bit_clock_in,
	output logic             rx_bit_clock_out,
	output logic             rx_bit_clock_oe,
	input  wire logic        rx_frame_sync_in,
	output logic             rx_frame_sync_out,
	output logic             rx_frame_sync_oe,
	input  wire logic        tx_bit_clock_in,
	output logic             tx_bit_clock_out,
	output logic             tx_bit_clock_oe,
	input  wire logic        tx_frame_sync_in,
	output logic             tx_frame_sync_out,
	output logic             tx_frame_sync_oe,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	input  wire logic        serial_data_in,
	output logic             tx_dma_event,
	output logic             rx_dma_event,
	output logic             tx_interrupt,
	output logic             rx_interrupt,
	output logic             rx_uses_rate_gen,
	output logic             rx_uses_frame_gen,
	output logic             tx_uses_rate_gen,
	output logic             tx_uses_frame_gen
);
	localparam int dw = sp_reset_pkg::divider_width;
	localparam int pw = sp_reset_pkg::period_width;

	logic [31:0] port_control_reg;
	logic [31:0] rate_gen_config_reg;
	logic [31:0] pin_control_reg;
	logic [31:0] transmit_holding_reg;
	logic [31:0] transmit_shift_reg;
	logic [31:0] next_port_control_reg;
	logic [31:0] next_rate_gen_config_reg;
	logic [31:0] next_pin_control_reg;
	logic [31:0] next_transmit_holding_reg;
	logic [31:0] next_transmit_shift_reg;
	logic [31:0] next_prdata;
	logic        holding_full;
	logic        next_holding_full;
	logic [1:0]  err_cnt;
	logic [1:0]  next_err_cnt;
	logic        tx_first_done;
	logic        next_tx_first_done;
	logic        rx_sample;
	logic        next_rx_sample;
	logic [1:0]  tx_clk_sync;
	logic [1:0]  next_tx_clk_sync;

	logic receiver_reset_n;
	logic transmitter_reset_n;
	logic rate_gen_reset_n;
	logic frame_gen_reset_n;
	logic tx_frame_source_select;
	logic tx_ready_flag;
	logic rx_ready_flag;
	logic tx_shift_not_empty;
	logic tx_sync_error;
	logic generated_clock;
	logic generated_frame_sync;
	logic clock_rise;
	logic wr;
	logic rd;
	logic copy;
	logic tx_edge;
	logic tx_clk_edge;

	assign receiver_reset_n =
		port_control_reg[sp_reset_pkg::receiver_reset_bit];
	assign transmitter_reset_n =
		port_control_reg[sp_reset_pkg::transmitter_reset_bit];
	assign rate_gen_reset_n =
		port_control_reg[sp_reset_pkg::rate_gen_reset_bit];
	assign frame_gen_reset_n =
		port_control_reg[sp_reset_pkg::frame_gen_reset_bit];
	assign tx_frame_source_select =
		pin_control_reg[sp_reset_pkg::tx_frame_source_bit];
	assign tx_sync_error =
		port_control_reg[sp_reset_pkg::tx_sync_error_bit];
	assign tx_shift_not_empty =
		port_control_reg[sp_reset_pkg::tx_shift_not_empty_bit];

	// Zero-wait slave; every offset answers
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	sp_rate_gen #(
		.div_width(dw),
		.per_width(pw)
	) u_rate_gen (
		.pclk                (pclk),
		.presetn             (presetn),
		.gen_run             (rate_gen_reset_n),
		.frame_run           (frame_gen_reset_n),
		.divider             (rate_gen_config_reg[
			sp_reset_pkg::divider_lsb +: dw]),
		.frame_period        (rate_gen_config_reg[
			sp_reset_pkg::period_lsb +: pw]),
		.generated_clock     (generated_clock),
		.clock_rise          (clock_rise),
		.generated_frame_sync(generated_frame_sync)
	);

	// ==========================================
	// Source and generator use
	// Internal receive sync draws on both generators
	assign rx_uses_frame_gen =
		pin_control_reg[sp_reset_pkg::rx_fs_out_bit];
	assign rx_uses_rate_gen = rx_uses_frame_gen ||
		pin_control_reg[sp_reset_pkg::rx_clock_out_bit];
	assign tx_uses_rate_gen =
		pin_control_reg[sp_reset_pkg::tx_clock_out_bit];
	// Generator sync only legal with internal clock
	assign tx_uses_frame_gen = tx_uses_rate_gen &&
		pin_control_reg[sp_reset_pkg::tx_fs_out_bit] &&
		tx_frame_source_select;

	// ==========================================
	// Pins
	always_comb begin
		rx_bit_clock_oe = pin_control_reg[sp_reset_pkg::rx_clock_out_bit];
		tx_bit_clock_oe = pin_control_reg[sp_reset_pkg::tx_clock_out_bit];
		// Clock pins keep running while a section is reset
		rx_bit_clock_out = generated_clock;
		tx_bit_clock_out = generated_clock;
		rx_frame_sync_oe = pin_control_reg[sp_reset_pkg::rx_fs_out_bit];
		tx_frame_sync_oe = pin_control_reg[sp_reset_pkg::tx_fs_out_bit];
		// Polarity bit is the inactive level
		rx_frame_sync_out = pin_control_reg[sp_reset_pkg::rx_fs_pol_bit];
		tx_frame_sync_out = pin_control_reg[sp_reset_pkg::tx_fs_pol_bit];
		if (receiver_reset_n)
			rx_frame_sync_out = rx_frame_sync_out ^ generated_frame_sync;
		if (transmitter_reset_n) begin
			if (tx_uses_frame_gen)
				tx_frame_sync_out = tx_frame_sync_out ^ generated_frame_sync;
			else
				tx_frame_sync_out = tx_frame_sync_out ^ copy;
		end
		serial_data_out = transmit_shift_reg[31];
		serial_data_out_oe = transmitter_reset_n;
	end

	// ==========================================
	// Service requests
	// Requests reach the pins only while the section runs
	assign tx_ready_flag = port_control_reg[sp_reset_pkg::tx_ready_bit];
	assign rx_ready_flag = port_control_reg[sp_reset_pkg::rx_ready_bit];
	assign tx_dma_event = tx_ready_flag && transmitter_reset_n;
	assign tx_interrupt = tx_dma_event;
	assign rx_dma_event = rx_ready_flag && receiver_reset_n;
	assign rx_interrupt = rx_dma_event;

	// Bit clock edge seen by the transmitter
	assign tx_clk_edge = tx_clk_sync[1] && !tx_clk_sync[0];
	assign tx_edge = tx_bit_clock_oe ? clock_rise : tx_clk_edge;
	assign copy = transmitter_reset_n && holding_full && tx_edge;

	// ==========================================
	// Register and status state
	always_comb begin
		next_port_control_reg = port_control_reg;
		next_rate_gen_config_reg = rate_gen_config_reg;
		next_pin_control_reg = pin_control_reg;
		next_transmit_holding_reg = transmit_holding_reg;
		next_transmit_shift_reg = transmit_shift_reg;
		next_holding_full = holding_full;
		next_err_cnt = err_cnt;
		next_tx_first_done = tx_first_done;
		next_rx_sample = rx_sample;
		next_tx_clk_sync = {tx_clk_sync[0], tx_bit_clock_in};
		next_prdata = prdata;
		if (rd) begin
			case (paddr)
				sp_reset_pkg::port_control_off:
					next_prdata = port_control_reg;
				sp_reset_pkg::rate_gen_config_off:
					next_prdata = rate_gen_config_reg;
				sp_reset_pkg::pin_control_off:
					next_prdata = pin_control_reg;
				default:
					next_prdata = 32'h0000_0000;
			endcase
		end
		// Transmitter state
		if (!transmitter_reset_n) begin
			// Zero stops the section; clears pending error
			next_port_control_reg[sp_reset_pkg::tx_sync_error_bit] =
				1'b0;
			next_port_control_reg[sp_reset_pkg::tx_ready_bit] = 1'b0;
			next_port_control_reg[sp_reset_pkg::tx_shift_not_empty_bit] =
				1'b0;
			next_holding_full = 1'b0;
			next_err_cnt = '0;
		end else begin
			next_port_control_reg[sp_reset_pkg::tx_ready_bit] =
				!holding_full;
			if (copy) begin
				next_transmit_shift_reg = transmit_holding_reg;
				next_holding_full = 1'b0;
				next_port_control_reg[sp_reset_pkg::tx_shift_not_empty_bit] =
					1'b1;
			end else if (tx_edge) begin
				next_transmit_shift_reg = {transmit_shift_reg[30:0], 1'b0};
			end
			// First enable: stray error within two bit clocks
			if (!tx_first_done && tx_edge) begin
				next_err_cnt = err_cnt + 1'b1;
				if (err_cnt == 2'(sp_reset_pkg::sync_error_clocks - 1)) begin
					next_tx_first_done = 1'b1;
					if (!tx_uses_frame_gen && !tx_frame_sync_oe &&
						!tx_frame_sync_in)
						next_port_control_reg[
							sp_reset_pkg::tx_sync_error_bit] = 1'b1;
				end
			end
		end
		// Receiver state
		if (!receiver_reset_n) begin
			next_port_control_reg[sp_reset_pkg::rx_ready_bit] = 1'b0;
		end else if (clock_rise || !rx_bit_clock_oe) begin
			next_rx_sample = serial_data_in;
			next_port_control_reg[sp_reset_pkg::rx_ready_bit] = 1'b1;
		end
		if (wr) begin
			case (paddr)
				sp_reset_pkg::port_control_off: begin
					// Control bits written one by one
					next_port_control_reg[3:0] = pwdata[3:0];
					if (!pwdata[sp_reset_pkg::transmitter_reset_bit])
						next_port_control_reg[
							sp_reset_pkg::tx_sync_error_bit] = 1'b0;
				end
				sp_reset_pkg::rate_gen_config_off:
					next_rate_gen_config_reg = pwdata;
				sp_reset_pkg::pin_control_off:
					next_pin_control_reg = pwdata;
				sp_reset_pkg::transmit_holding_off: begin
					next_transmit_holding_reg = pwdata;
					next_holding_full = transmitter_reset_n;
				end
				sp_reset_pkg::emu_reset_off:
					if (pwdata == sp_reset_pkg::emu_reset_key) begin
						next_port_control_reg =
							sp_reset_pkg::port_control_reset;
						next_rate_gen_config_reg =
							sp_reset_pkg::rate_gen_config_reset;
						next_pin_control_reg =
							sp_reset_pkg::pin_control_reset;
						// Transmit path emptied too, no stale word
						next_transmit_holding_reg = 32'h0000_0000;
						next_transmit_shift_reg = 32'h0000_0000;
						next_err_cnt = '0;
						next_holding_full = 1'b0;
					end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_control_reg <= sp_reset_pkg::port_control_reset;
			rate_gen_config_reg <= sp_reset_pkg::rate_gen_config_reset;
			pin_control_reg <= sp_reset_pkg::pin_control_reset;
			transmit_holding_reg <= 32'h0000_0000;
			transmit_shift_reg <= 32'h0000_0000;
			holding_full <= 1'b0;
			err_cnt <= 2'h0;
			tx_first_done <= 1'b0;
			rx_sample <= 1'b0;
			tx_clk_sync <= 2'h0;
			prdata <= 32'h0000_0000;
		end else begin
			port_control_reg <= next_port_control_reg;
			rate_gen_config_reg <= next_rate_gen_config_reg;
			pin_control_reg <= next_pin_control_reg;
			transmit_holding_reg <= next_transmit_holding_reg;
			transmit_shift_reg <= next_transmit_shift_reg;
			holding_full <= next_holding_full;
			err_cnt <= next_err_cnt;
			tx_first_done <= next_tx_first_done;
			rx_sample <= next_rx_sample;
			tx_clk_sync <= next_tx_clk_sync;
			prdata <= next_prdata;
		end
	end
endmodule : serial_port_reset_init

// ===== verilog/sp_rate_gen.sv
`timescale 1ns/1ps
// ==========================================
// Rate and frame generator
module sp_rate_gen #(
	parameter int div_width = 8,
	parameter int per_width = 8
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 gen_run,
	input  wire logic                 frame_run,
	input  wire logic [div_width-1:0] divider,
	input  wire logic [per_width-1:0] frame_period,
	output logic                      generated_clock,
	output logic                      clock_rise,
	output logic                      generated_frame_sync
);
	logic [div_width-1:0] div_cnt;
	logic [div_width-1:0] next_div_cnt;
	logic                 next_generated_clock;
	logic [per_width:0]   frame_cnt;
	logic [per_width:0]   next_frame_cnt;
	logic                 next_generated_frame_sync;
	logic [per_width:0]   start_count;

	always_comb begin
		start_count = (per_width+1)'(sp_reset_pkg::frame_start_delay);
		next_div_cnt = div_cnt;
		next_generated_clock = generated_clock;
		next_frame_cnt = frame_cnt;
		next_generated_frame_sync = generated_frame_sync;
		clock_rise = 1'b0;
		if (!gen_run) begin
			next_div_cnt = '0;
			next_generated_clock = 1'b0;
			next_generated_frame_sync = 1'b0;
			next_frame_cnt = start_count;
		end else if (div_cnt == '0) begin
			// High on first edge, then toggles every divider+1 edges
			next_generated_clock = !generated_clock;
			next_div_cnt = divider;
			clock_rise = !generated_clock;
			if (!generated_clock) begin
				if (!frame_run) begin
					next_frame_cnt = start_count;
					next_generated_frame_sync = 1'b0;
				end else if (frame_cnt == '0) begin
					next_generated_frame_sync = 1'b1;
					next_frame_cnt = {1'b0, frame_period};
				end else begin
					next_generated_frame_sync = 1'b0;
					next_frame_cnt = frame_cnt - 1'b1;
				end
			end
		end else begin
			next_div_cnt = div_cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			generated_clock <= 1'b0;
			frame_cnt <= '0;
			generated_frame_sync <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			generated_clock <= next_generated_clock;
			frame_cnt <= next_frame_cnt;
			generated_frame_sync <= next_generated_frame_sync;
		end
	end
endmodule : sp_rate_gen

// ===== verilog/sp_reset_pkg.sv
// How it works
// - Zero section reset bit stops that section
// - Reset section drives frame sync inactive level
// - Output bit clock follows generated clock
// - Data output tristated while transmitter reset
// - Rate generator reset holds clock, sync low
// - Reset section masks generated frame sync
// - Emulator reset restores all register defaults
// - Device reset clears all four reset bits
// - Each section reset bit written independently
// - Receiver generator use follows source config
// - Transmit sync from generator or copy
// - External clock internal sync needs copy mode
// - Clock rises next edge, toggles every divider+1 edges
// - Sync error appears early, cleared by reset
// - Running section raises event, interrupt, ready
// - First frame sync after 7 to 8 periods
package sp_reset_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] port_control_off = 8'h00;
	localparam logic [7:0] rate_gen_config_off = 8'h04;
	localparam logic [7:0] pin_control_off = 8'h08;
	localparam logic [7:0] transmit_holding_off = 8'h0c;
	localparam logic [7:0] emu_reset_off = 8'h10;
	// ==========================================
	// Port control fields
	localparam int receiver_reset_bit = 0;
	localparam int transmitter_reset_bit = 1;
	localparam int rate_gen_reset_bit = 2;
	localparam int frame_gen_reset_bit = 3;
	localparam int rx_ready_bit = 4;
	localparam int tx_ready_bit = 5;
	localparam int tx_shift_not_empty_bit = 6;
	localparam int tx_sync_error_bit = 7;
	// ==========================================
	// Pin control fields
	localparam int rx_clock_out_bit = 0;
	localparam int tx_clock_out_bit = 1;
	localparam int rx_fs_out_bit = 2;
	localparam int tx_fs_out_bit = 3;
	localparam int rx_fs_pol_bit = 4;
	localparam int tx_fs_pol_bit = 5;
	localparam int tx_frame_source_bit = 6;
	// ==========================================
	// Rate generator config fields
	localparam int divider_lsb = 0;
	localparam int divider_width = 8;
	localparam int period_lsb = 8;
	localparam int period_width = 8;
	// ==========================================
	// Reset values and counts
	localparam logic [31:0] port_control_reset = 32'h0000_0000;
	localparam logic [31:0] rate_gen_config_reset = 32'h0000_0f01;
	localparam logic [31:0] pin_control_reset = 32'h0000_0000;
	localparam logic [31:0] emu_reset_key = 32'h0000_00a5;
	localparam int frame_start_delay = 7;
	localparam int sync_error_clocks = 2;
endpackage : sp_reset_pkg
